// ==== bench/bus_master_model.sv ====
// Behavioural two-wire bus master driving the slave's serial lines
`timescale 1ns/1ps
module bus_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Idle bus: clock stands high, data released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Open a transfer from an idle bus
  task automatic start();
    sda_o = 1'b0;
    #1000;
    scl_o = 1'b0;
    #500;
  endtask
  // One clock pulse: data set while low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    sda_o = b;
    #500;
    scl_o = 1'b1;
    #500;
    s = sda_i;
    #500;
    scl_o = 1'b0;
    #500;
  endtask
  // Byte MSB first, then a released ninth pulse for the answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Close the transfer and leave the bus free
  task automatic stop();
    sda_o = 1'b0;
    #500;
    scl_o = 1'b1;
    #1000;
    sda_o = 1'b1;
    #1000;
  endtask
endmodule

// ==== bench/serial_eeprom_bus_slave_monitor.sv ====
// Port-level assertions for the serial EEPROM bus slave
`timescale 1ns/1ps
module serial_eeprom_bus_slave_monitor #(
  parameter int prog_cycles = 20
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire eeprom_slave_pkg::prog_port_s prog_o,
  input wire logic busy_o
);
  int gap_q;
  logic seen_q;
  // Cycles since the last array write, and whether one came in this busy period
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= prog_o.we ? 1 : gap_q + 1;
      seen_q <= busy_o & (prog_o.we | seen_q);
    end
  end
  property p_oe_scl_low;
    @(posedge link_clk_i) disable iff (!arst_n_i) $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("ack moved in clock high");
  property p_oe_wire;
    @(posedge link_clk_i) disable iff (!arst_n_i) sda_oe_o |-> !sda_o && !sda_i;
  endproperty
  a_oe_wire: assert property (p_oe_wire) else $error("ack not pulling low");
  property p_no_ack_busy;
    @(posedge link_clk_i) disable iff (!arst_n_i) busy_o |-> !$rose(sda_oe_o);
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while busy");
  property p_ack_len;
    @(posedge link_clk_i) disable iff (!arst_n_i) $rose(sda_oe_o) |-> ##[8:24] !sda_oe_o;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack longer than one bit");
  property p_we_busy;
    @(posedge clock_i) disable iff (!arst_n_i) prog_o.we |-> busy_o;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("write outside program cycle");
  property p_busy_we;
    @(posedge clock_i) disable iff (!arst_n_i) $rose(busy_o) |=> prog_o.we;
  endproperty
  a_busy_we: assert property (p_busy_we) else $error("program cycle without write");
  property p_we_gap;
    @(posedge clock_i) disable iff (!arst_n_i) prog_o.we && seen_q |-> gap_q == prog_cycles;
  endproperty
  a_we_gap: assert property (p_we_gap) else $error("byte write spacing wrong");
  property p_we_pulse;
    @(posedge clock_i) disable iff (!arst_n_i) prog_o.we |=> !prog_o.we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
endmodule

bind serial_eeprom_bus_slave serial_eeprom_bus_slave_monitor #(.prog_cycles(prog_cycles)) mon_i (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_o(prog_o), .busy_o(busy_o));

// ==== bench/test_serial_eeprom_bus_slave.sv ====
// Self-checking bench for the serial EEPROM bus slave
`timescale 1ns/1ps
module test_serial_eeprom_bus_slave;
  localparam int PC = 2000;
  localparam logic [2:0] CS = 3'h5;
  localparam logic [2:0] CSL = 3'h6;
  localparam logic [3:0] DEV = eeprom_slave_pkg::DEV_CODE_DEFAULT;
  logic clock_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] cs_q = CS;
  logic [2:0] cs_l = CSL;
  logic m_scl, m_sda, sda_o, sda_oe_o, busy_o, sda_w;
  logic sda_o_l, sda_oe_l, busy_l;
  eeprom_slave_pkg::prog_port_s prog_o;
  eeprom_slave_pkg::prog_port_s prog_l;
  logic [8:0] pa[$];
  logic [7:0] pd[$];
  logic [8:0] la[$];
  logic [7:0] ld[$];
  int bcnt = 0;
  int bad_count = 0;
  int cmp_count = 0;
  always #5 clock_i = ~clock_i;
  always #62.5 link_clk_i = ~link_clk_i;
  // Open-drain wire with pull-up
  assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1) & (sda_oe_l ? sda_o_l : 1'b1);
  serial_eeprom_bus_slave #(.prog_cycles(PC)) serial_eeprom_bus_slave_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i), .scl_i(m_scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_low_bit(cs_q[0]),
    .chip_select_mid_bit(cs_q[1]), .chip_select_high_bit(cs_q[2]), .prog_o(prog_o),
    .busy_o(busy_o));
  // Large variant on the same bus; answers select codes with high and mid bits set
  serial_eeprom_bus_slave #(.large_variant(1'b1), .prog_cycles(PC))
    serial_eeprom_bus_slave_large_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i), .scl_i(m_scl),
    .sda_i(sda_w), .sda_o(sda_o_l), .sda_oe_o(sda_oe_l), .chip_select_low_bit(cs_l[0]),
    .chip_select_mid_bit(cs_l[1]), .chip_select_high_bit(cs_l[2]), .prog_o(prog_l),
    .busy_o(busy_l));
  bus_master_model bus_master_model_i (.sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  // Record array writes and busy time
  always @(posedge clock_i) begin
    if (prog_o.we === 1'b1) begin
      pa.push_back(prog_o.addr);
      pd.push_back(prog_o.data);
    end
    if (prog_l.we === 1'b1) begin
      la.push_back(prog_l.addr);
      ld.push_back(prog_l.data);
    end
    bcnt += int'(busy_o === 1'b1);
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic check_word(input logic [8:0] got, input logic [8:0] exp, input string msg);
    check_bit(got === exp, 1'b1, msg);
  endtask
  // Send one byte and compare the answer
  task automatic wr(input logic [7:0] b, input logic exp, input string msg);
    logic ack;
    bus_master_model_i.put_byte(b, ack);
    check_bit(ack, exp, msg);
  endtask
  function automatic logic [7:0] adr(input logic [2:0] cs, input logic rw);
    return {DEV, cs, rw};
  endfunction
  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while ((busy_o | busy_l) !== 1'b0 && n < 30000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 30000) begin
      check_bit(1'b0, 1'b1, "busy never ended");
      stop_test();
    end
  endtask
  // Foreign select and foreign type code are ignored
  task automatic s_foreign();
    bus_master_model_i.start();
    wr(adr(~CS, 1'b0), 1'b0, "foreign select acked");
    bus_master_model_i.stop();
    bus_master_model_i.start();
    wr({DEV ^ 4'h8, CS, 1'b0}, 1'b0, "foreign code acked");
    bus_master_model_i.stop();
  endtask
  // Full page, polled while busy and after
  task automatic s_page();
    pa = {};
    bcnt = 0;
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b1, "address refused");
    wr(8'h35, 1'b1, "word refused");
    wr(8'ha5, 1'b1, "data refused");
    wr(8'h3c, 1'b1, "second data refused");
    bus_master_model_i.stop();
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b0, "ack while busy");
    bus_master_model_i.stop();
    wait_idle();
    check_word(9'(pa.size()), 9'h002, "write count");
    check_word(pa[0], 9'h035, "first address");
    check_word(pa[1], 9'h034, "second address");
    check_word({1'b0, pd[0]}, 9'h0a5, "first data");
    check_word({1'b0, pd[1]}, 9'h03c, "second data");
    check_bit(bcnt >= 2 * PC && bcnt <= 2 * PC + 2, 1'b1, "program time");
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b1, "no ack when done");
    bus_master_model_i.stop();
  endtask
  // Third data byte refused, then a byte cut short by STOP
  task automatic s_abort();
    logic s;
    pa = {};
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b1, "address refused");
    wr(8'h10, 1'b1, "word refused");
    wr(8'h01, 1'b1, "data refused");
    wr(8'h02, 1'b1, "data refused");
    wr(8'h03, 1'b0, "third data acked");
    bus_master_model_i.stop();
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b1, "address refused");
    wr(8'h80, 1'b1, "word refused");
    repeat (4) bus_master_model_i.bit_io(1'b1, s);
    bus_master_model_i.stop();
    repeat (50) @(posedge clock_i);
    check_word(9'(pa.size()), 9'h000, "abandoned write programmed");
  endtask
  // Single byte write, then read direction
  task automatic s_single();
    pa = {};
    pd = {};
    bus_master_model_i.start();
    wr(adr(CS, 1'b0), 1'b1, "address refused");
    wr(8'h80, 1'b1, "word refused");
    wr(8'h11, 1'b1, "data refused");
    bus_master_model_i.stop();
    repeat (20) @(posedge clock_i);
    wait_idle();
    check_word(9'(pa.size()), 9'h001, "single write count");
    check_word(pa[0], 9'h080, "single address");
    check_word({1'b0, pd[0]}, 9'h011, "single data");
    bus_master_model_i.start();
    wr(adr(CS, 1'b1), 1'b1, "read address refused");
    bus_master_model_i.stop();
  endtask
  // Large variant: upper block, ten bytes wrap over the first two slots
  task automatic s_large();
    pa = {};
    la = {};
    ld = {};
    bus_master_model_i.start();
    wr(adr(CSL | 3'h1, 1'b0), 1'b1, "large address refused");
    wr(8'hfe, 1'b1, "large word refused");
    for (int i = 0; i < 10; i++) begin
      wr(8'(8'h40 + i), 1'b1, "large data refused");
    end
    bus_master_model_i.stop();
    wait_idle();
    check_word(9'(pa.size()), 9'h000, "small device took large write");
    check_word(9'(la.size()), 9'h008, "large write count");
    for (int k = 0; k < 8; k++) begin
      check_word(la[k], {6'h3f, 3'(6 + k)}, "large address");
      check_word({1'b0, ld[k]}, 9'(8'h40 + (k < 2 ? k + 8 : k)), "large data");
    end
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    #1000;
    s_foreign();
    s_page();
    s_abort();
    s_single();
    s_large();
    stop_test();
  end
endmodule

// ==== shared/eeprom_slave_pkg.sv ====
// Constants and carrier types for the serial EEPROM bus slave
package eeprom_slave_pkg;

  // Slave address byte layout
  localparam int ADDR_CODE_MSB = 7;
  localparam int ADDR_CODE_LSB = 4;
  localparam int ADDR_CS_HIGH = 3;
  localparam int ADDR_CS_MID = 2;
  localparam int ADDR_CS_LOW = 1;
  localparam int ADDR_DIR_BIT = 0;

  // Device type code; value is arbitrary and must be set per product
  localparam logic [3:0] DEV_CODE_DEFAULT = 4'h5;

  // Page buffer geometry
  localparam int PAGE_MAX = 8;
  localparam logic [3:0] PAGE_BYTES_LARGE = 4'h8;
  localparam logic [3:0] PAGE_BYTES_SMALL = 4'h2;
  localparam logic [8:0] PAGE_MASK_LARGE = 9'h007;
  localparam logic [8:0] PAGE_MASK_SMALL = 9'h001;

  // Bit counter values
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Program cycle timing per buffered byte
  localparam int PROG_TIME_US = 1000;
  localparam int CLK_MHZ = 100;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // Reset values
  localparam logic [8:0] PTR_RESET = 9'h000;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // Link side bus state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_WAIT_FALL = 2'b10,
    ST_ACK = 2'b11
  } link_st_e;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WORD = 2'b01,
    PH_DATA = 2'b10,
    PH_READ = 2'b11
  } byte_ph_e;

  // Program cycle state
  typedef enum logic {
    CORE_IDLE = 1'b0,
    CORE_PROG = 1'b1
  } core_st_e;

  // One write to the array
  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] data;
  } prog_port_s;

endpackage

// ==== src/serial_eeprom_bus_slave.sv ====
// Two-wire bus slave front end with page buffer and self-timed program cycle
// Notes on behaviour
// RQ1 - SDA falling while SCL high is a START.
// RQ2 - SDA rising while SCL high is a STOP ending the operation.
// RQ3 - SDA changes only while SCL low; changes while high are START/STOP.
// RQ4 - Master opens every command with START and ends with STOP.
// RQ5 - Master starts a transfer only when both lines are high.
// RQ6 - One clock pulse per bit; byte count per transfer is unlimited.
// RQ7 - Addressed receiver acknowledges each byte on an extra ninth pulse.
// RQ8 - Acknowledger holds SDA low through the whole ninth clock-high phase.
// RQ9 - No acknowledge at all while a program cycle runs.
// RQ10 - After a read ends without master acknowledge, slave leaves SDA high.
// RQ11 - First byte holds 4-bit type code then three chip select bits.
// RQ12 - Eighth address bit low means write, high means read.
// RQ13 - Address acknowledged only when it matches and device is not busy.
// RQ14 - Large variant: lowest select bit picks array block, ninth pointer bit.
// RQ15 - Write: ack address on ninth clock, next byte loads pointer low bits.
// RQ16 - Each later byte is acknowledged and stored in sequence until STOP.
// RQ17 - Page buffer holds 2 bytes small, 8 bytes large.
// RQ18 - Small variant: third data byte is not acknowledged, write abandoned.
// RQ19 - Large variant: only low 3 pointer bits advance, so data wraps.
// RQ20 - STOP after data launches programming of buffered bytes in order.
// RQ21 - Program cycle lasts one millisecond per buffered byte.
// RQ22 - Write-address polling gets no ack while busy, ack when done.
// RQ23 - START or STOP mid-byte drops the byte; START never programs.
`timescale 1ns/1ps
module serial_eeprom_bus_slave #(
  parameter bit large_variant = 1'b0,
  parameter logic [3:0] dev_code = eeprom_slave_pkg::DEV_CODE_DEFAULT,
  parameter int prog_cycles = eeprom_slave_pkg::PROG_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_low_bit,
  input wire logic chip_select_mid_bit,
  input wire logic chip_select_high_bit,
  output eeprom_slave_pkg::prog_port_s prog_o,
  output logic busy_o
);

  localparam logic [3:0] page_bytes = large_variant ? eeprom_slave_pkg::PAGE_BYTES_LARGE
                                                    : eeprom_slave_pkg::PAGE_BYTES_SMALL;
  localparam logic [8:0] page_mask = large_variant ? eeprom_slave_pkg::PAGE_MASK_LARGE
                                                   : eeprom_slave_pkg::PAGE_MASK_SMALL;

  // ---------------- Link domain ----------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [2:0] cs_meta_q;
  logic [2:0] cs_q;
  logic scl_d_q;
  logic sda_d_q;
  logic busy_meta_q;
  logic busy_lk_q;
  logic ack_meta_q;
  logic ack_lk_q;
  logic ack_tgl_q;
  logic req_tgl_q;
  eeprom_slave_pkg::link_st_e st_q;
  eeprom_slave_pkg::byte_ph_e ph_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [8:0] ptr_q;
  logic [3:0] count_q;
  logic [2:0] slot_q;
  logic abort_q;
  logic [7:0] buf_q [eeprom_slave_pkg::PAGE_MAX];
  logic [8:0] cmt_addr_q;
  logic [3:0] cmt_count_q;
  logic sda_oe_q;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic pending;
  logic dev_busy;
  logic addr_match;
  logic [2:0] buf_idx;

  // Pins from the bus pass two flops before any logic reads them
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      cs_meta_q <= 3'h0;
      cs_q <= 3'h0;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      cs_meta_q <= {chip_select_high_bit, chip_select_mid_bit, chip_select_low_bit};
      cs_q <= cs_meta_q;
      scl_d_q <= scl_sync_q[1];
      sda_d_q <= sda_sync_q[1];
    end
  end

  // Status from the core domain: busy level and acknowledge toggle
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_meta_q <= 1'b0;
      busy_lk_q <= 1'b0;
      ack_meta_q <= 1'b0;
      ack_lk_q <= 1'b0;
    end else begin
      busy_meta_q <= busy_o;
      busy_lk_q <= busy_meta_q;
      ack_meta_q <= ack_tgl_q;
      ack_lk_q <= ack_meta_q;
    end
  end

  // Bus conditions seen on the synchronised lines
  assign scl_rise = scl_sync_q[1] & ~scl_d_q;
  assign scl_fall = ~scl_sync_q[1] & scl_d_q;
  assign start_det = scl_sync_q[1] & scl_d_q & sda_d_q & ~sda_sync_q[1]; // RQ1 RQ3
  assign stop_det = scl_sync_q[1] & scl_d_q & ~sda_d_q & sda_sync_q[1]; // RQ2 RQ3

  // Busy covers a handed-over page not yet taken by the core
  assign pending = req_tgl_q ^ ack_lk_q;
  assign dev_busy = pending | busy_lk_q; // RQ9

  // Address compare; the large variant skips the lowest select bit
  assign addr_match =
    (shift_q[eeprom_slave_pkg::ADDR_CODE_MSB:eeprom_slave_pkg::ADDR_CODE_LSB] == dev_code) &&
    (shift_q[eeprom_slave_pkg::ADDR_CS_HIGH] == cs_q[2]) &&
    (shift_q[eeprom_slave_pkg::ADDR_CS_MID] == cs_q[1]) &&
    (large_variant || (shift_q[eeprom_slave_pkg::ADDR_CS_LOW] == cs_q[0])); // RQ11 RQ14

  // Buffer slot keeps advancing past a full page, so late bytes overwrite from the first
  assign buf_idx = large_variant ? slot_q : {2'h0, slot_q[0]}; // RQ19

  // Bus state machine: bit shifting, acknowledge drive and byte handling
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= eeprom_slave_pkg::ST_IDLE;
      ph_q <= eeprom_slave_pkg::PH_ADDR;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      ptr_q <= eeprom_slave_pkg::PTR_RESET;
      count_q <= eeprom_slave_pkg::COUNT_RESET;
      abort_q <= 1'b0;
      sda_oe_q <= 1'b0;
      req_tgl_q <= 1'b0;
      slot_q <= 3'h0;
      cmt_addr_q <= eeprom_slave_pkg::PTR_RESET;
      cmt_count_q <= eeprom_slave_pkg::COUNT_RESET;
    end else if (start_det) begin
      // Partial byte dropped, wait for an address again
      st_q <= eeprom_slave_pkg::ST_RX; // RQ23 RQ13
      ph_q <= eeprom_slave_pkg::PH_ADDR;
      bit_cnt_q <= 3'h0;
      count_q <= eeprom_slave_pkg::COUNT_RESET;
      abort_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      // Launch programming only for a complete, unaborted write
      if (ph_q == eeprom_slave_pkg::PH_DATA && count_q != 4'h0 && !abort_q && !dev_busy) begin
        req_tgl_q <= ~req_tgl_q; // RQ20
        cmt_addr_q <= ptr_q;
        cmt_count_q <= count_q;
      end
      st_q <= eeprom_slave_pkg::ST_IDLE; // RQ2 RQ23
      ph_q <= eeprom_slave_pkg::PH_ADDR;
      bit_cnt_q <= 3'h0;
      count_q <= eeprom_slave_pkg::COUNT_RESET;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        eeprom_slave_pkg::ST_IDLE: begin
          sda_oe_q <= 1'b0; // RQ10
        end
        eeprom_slave_pkg::ST_RX: begin
          // One bit per clock pulse, taken from the last SDA sample before SCL rose
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_d_q}; // RQ6 RQ3
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == eeprom_slave_pkg::BIT_LAST) begin
              st_q <= eeprom_slave_pkg::ST_WAIT_FALL;
            end
          end
        end
        eeprom_slave_pkg::ST_WAIT_FALL: begin
          // Eighth pulse ended: decide whether to acknowledge
          if (scl_fall) begin
            st_q <= eeprom_slave_pkg::ST_IDLE;
            unique case (ph_q)
              eeprom_slave_pkg::PH_ADDR: begin
                if (addr_match && !dev_busy) begin // RQ13 RQ22 RQ9
                  sda_oe_q <= 1'b1; // RQ7 RQ8
                  st_q <= eeprom_slave_pkg::ST_ACK;
                  if (shift_q[eeprom_slave_pkg::ADDR_DIR_BIT]) begin // RQ12
                    ph_q <= eeprom_slave_pkg::PH_READ;
                  end else begin
                    ph_q <= eeprom_slave_pkg::PH_WORD;
                    ptr_q[8] <= large_variant & shift_q[eeprom_slave_pkg::ADDR_CS_LOW]; // RQ14
                  end
                end
              end
              eeprom_slave_pkg::PH_WORD: begin
                if (!dev_busy) begin // RQ9
                  ptr_q[7:0] <= shift_q; // RQ15
                  count_q <= eeprom_slave_pkg::COUNT_RESET;
                  slot_q <= 3'h0;
                  ph_q <= eeprom_slave_pkg::PH_DATA;
                  sda_oe_q <= 1'b1; // RQ15 RQ7
                  st_q <= eeprom_slave_pkg::ST_ACK;
                end
              end
              eeprom_slave_pkg::PH_DATA: begin
                if (!large_variant && count_q == page_bytes) begin
                  abort_q <= 1'b1; // RQ18
                end else if (!dev_busy) begin
                  // Store in sequence; large page wraps over the first entries
                  buf_q[buf_idx] <= shift_q; // RQ16 RQ17 RQ19
                  slot_q <= slot_q + 3'h1; // RQ19
                  if (count_q != page_bytes) begin
                    count_q <= count_q + 4'h1;
                  end
                  sda_oe_q <= 1'b1; // RQ16 RQ7
                  st_q <= eeprom_slave_pkg::ST_ACK;
                end
              end
              eeprom_slave_pkg::PH_READ: begin
                sda_oe_q <= 1'b0; // RQ10
              end
            endcase
          end
        end
        eeprom_slave_pkg::ST_ACK: begin
          // Hold SDA low until the acknowledge pulse has ended
          if (scl_fall) begin
            sda_oe_q <= 1'b0; // RQ8
            bit_cnt_q <= 3'h0;
            st_q <= (ph_q == eeprom_slave_pkg::PH_READ) ? eeprom_slave_pkg::ST_IDLE
                                                        : eeprom_slave_pkg::ST_RX;
          end
        end
      endcase
    end
  end

  // Open-drain drive: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // ---------------- Core domain ----------------
  logic req_meta_q;
  logic req_core_q;
  logic req_seen_q;
  logic ack_pend_q;
  eeprom_slave_pkg::core_st_e core_q;
  logic [7:0] page_q [eeprom_slave_pkg::PAGE_MAX];
  logic [8:0] start_q;
  logic [3:0] num_q;
  logic [3:0] k_q;
  logic [31:0] timer_q;
  logic [8:0] wr_addr;
  logic [8:0] k_ext;
  logic new_req;

  // Commit toggle from the link domain
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_meta_q <= 1'b0;
      req_core_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_meta_q <= req_tgl_q;
      req_core_q <= req_meta_q;
      req_seen_q <= req_core_q;
    end
  end

  assign new_req = req_core_q ^ req_seen_q;

  // Page copy: link buffer is frozen while the request is pending
  always_ff @(posedge clock_i) begin
    if (new_req) begin
      page_q <= buf_q;
    end
  end

  // Acknowledge toggles one cycle after busy rises so the link never sees a gap
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_pend_q <= 1'b0;
      ack_tgl_q <= 1'b0;
    end else begin
      ack_pend_q <= new_req;
      if (ack_pend_q) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // Address of byte k within the page; low bits wrap inside the page
  assign k_ext = {5'h00, k_q};
  assign wr_addr = (start_q & ~page_mask) | ((start_q + k_ext) & page_mask); // RQ19

  // Self-timed program cycle, one slot per buffered byte
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_q <= eeprom_slave_pkg::CORE_IDLE;
      busy_o <= 1'b0;
      start_q <= eeprom_slave_pkg::PTR_RESET;
      num_q <= eeprom_slave_pkg::COUNT_RESET;
      k_q <= 4'h0;
      timer_q <= 32'h0;
    end else begin
      unique case (core_q)
        eeprom_slave_pkg::CORE_IDLE: begin
          if (new_req) begin
            core_q <= eeprom_slave_pkg::CORE_PROG; // RQ20
            busy_o <= 1'b1; // RQ9
            start_q <= cmt_addr_q;
            num_q <= cmt_count_q;
            k_q <= 4'h0;
            timer_q <= 32'h0;
          end
        end
        eeprom_slave_pkg::CORE_PROG: begin
          if (timer_q == 32'(prog_cycles - 1)) begin // RQ21
            timer_q <= 32'h0;
            if (k_q + 4'h1 == num_q) begin
              core_q <= eeprom_slave_pkg::CORE_IDLE;
              busy_o <= 1'b0; // RQ22
            end else begin
              k_q <= k_q + 4'h1; // RQ20
            end
          end else begin
            timer_q <= timer_q + 32'h1;
          end
        end
      endcase
    end
  end

  // Array write strobe at the start of each byte slot
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prog_o <= '0;
    end else begin
      prog_o.we <= (core_q == eeprom_slave_pkg::CORE_PROG) && (timer_q == 32'h0); // RQ20
      prog_o.addr <= wr_addr;
      prog_o.data <= page_q[k_q[2:0]];
    end
  end

endmodule
